/* File: hw/fetch_pkg.sv */
// constants for the vertex fetch front end: register map, fields, codes
// assumes a 32-bit register port with byte addresses
`default_nettype none
package fetch_pkg;
  // register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_VCOUNT = 8'h04;
  localparam logic [7:0] A_FIRST  = 8'h08;
  localparam logic [7:0] A_IDXB   = 8'h0C;
  localparam logic [7:0] A_SRCB   = 8'h10;
  localparam logic [7:0] A_SRCLEN = 8'h14;
  localparam logic [7:0] A_STRIDE = 8'h18;
  localparam logic [7:0] A_INST   = 8'h1C;
  localparam logic [7:0] A_STATUS = 8'h20;
  localparam logic [7:0] A_PKTCNT = 8'h24;
  localparam logic [7:0] A_OOBCNT = 8'h28;
  localparam logic [7:0] A_POSX   = 8'h2C;
  localparam logic [7:0] A_POSY   = 8'h30;
  localparam logic [7:0] A_POSZ   = 8'h34;
  localparam logic [7:0] A_POSW   = 8'h38;
  localparam logic [7:0] A_POSGO  = 8'h3C;
  localparam logic [7:0] A_VIEW   = 8'h40;
  localparam logic [7:0] A_NORMX  = 8'h44;
  localparam logic [7:0] A_NORMY  = 8'h48;
  localparam logic [7:0] A_NORMZ  = 8'h4C;
  localparam logic [7:0] A_RECIPW = 8'h50;
  localparam logic [7:0] A_SCRX   = 8'h54;
  localparam logic [7:0] A_SCRY   = 8'h58;
  // control field positions
  localparam int unsigned C_START   = 0;
  localparam int unsigned C_INDEXED = 1;
  localparam int unsigned C_ISZ     = 2;
  localparam int unsigned C_BYPASS  = 4;
  localparam int unsigned C_INST    = 5;
  localparam int unsigned C_TOPO    = 8;
  localparam int unsigned TOPO_W    = 6;
  localparam logic [31:0] CTRL_WMASK = 32'h00003F3E;
  localparam logic [31:0] RST_REG    = 32'h00000000;
  // index entry size codes
  localparam logic [1:0] ISZ_8  = 2'h0;
  localparam logic [1:0] ISZ_16 = 2'h1;
  // topology codes
  localparam logic [5:0] T_RECTLIST  = 6'h0F;
  localparam logic [5:0] T_FAN_NOSTP = 6'h14;
  // one bit per topology code: cut index recognised
  localparam logic [63:0] CUT_MASK = 64'h00000000000F7C3E;
  // element and arithmetic constants
  localparam logic [63:0] ELEM_BYTES = 64'h0000000000000004;
  localparam logic [63:0] ONE_Q      = 64'h0000000000010000;
  localparam logic [31:0] SAT_POS    = 32'h7FFFFFFF;
  localparam logic [5:0]  DIV_LAST   = 6'h20;
endpackage
`default_nettype wire

/* File: hw/clip_pos_map.sv */
// position mapper: clip space to normalized and screen coordinates
// assumes Q16.16 inputs held stable while busy
`default_nettype none
module clip_pos_map (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        go_i,
  input  wire logic        bypass_i,
  input  wire logic [31:0] pos_x_i,
  input  wire logic [31:0] pos_y_i,
  input  wire logic [31:0] pos_z_i,
  input  wire logic [31:0] pos_w_i,
  input  wire logic [15:0] view_w_i,
  input  wire logic [15:0] view_h_i,
  output logic             busy_o,
  output logic             nonfinite_o,
  output logic [31:0]      norm_x_o,
  output logic [31:0]      norm_y_o,
  output logic [31:0]      norm_z_o,
  output logic [31:0]      recip_w_o,
  output logic [31:0]      scr_x_o,
  output logic [31:0]      scr_y_o
);
  typedef enum logic [1:0] {P_IDLE, P_DIV, P_MAP} pstate_t;
  pstate_t            st_ff;
  logic [31:0]        den_ff;
  logic               neg_ff;
  logic [32:0]        rem_ff;
  logic [32:0]        quo_ff;
  logic [5:0]         cnt_ff;
  logic               byp_ff;
  wire  [33:0]        shl   = {rem_ff, (cnt_ff == 6'h00)};
  wire                ge    = shl >= {2'b00, den_ff};
  wire  [31:0]        q_sat = (|quo_ff[32:31]) ? fetch_pkg::SAT_POS : quo_ff[31:0];
  wire  [31:0]        recip = neg_ff ? 32'(-q_sat) : q_sat;
  wire  signed [63:0] px    = 64'($signed(pos_x_i)) * 64'($signed(recip));
  wire  signed [63:0] py    = 64'($signed(pos_y_i)) * 64'($signed(recip));
  wire  signed [63:0] pz    = 64'($signed(pos_z_i)) * 64'($signed(recip));
  wire  [31:0]        nx    = byp_ff ? pos_x_i : px[47:16];
  wire  [31:0]        ny    = byp_ff ? pos_y_i : py[47:16];
  wire  [31:0]        nz    = byp_ff ? pos_z_i : pz[47:16];
  wire  signed [63:0] tx    = (64'($signed(nx)) + $signed(fetch_pkg::ONE_Q))
                              * $signed({48'h0, view_w_i});
  wire  signed [63:0] ty    = ($signed(fetch_pkg::ONE_Q) - 64'($signed(ny)))
                              * $signed({48'h0, view_h_i});
  wire  [31:0]        sx    = byp_ff ? 32'($signed(pos_x_i) >>> 16) : tx[48:17];
  wire  [31:0]        sy    = byp_ff ? 32'($signed(pos_y_i) >>> 16) : ty[48:17];

  assign busy_o = (st_ff != P_IDLE);

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_ff <= P_IDLE;
      den_ff <= 32'h0;
      neg_ff <= 1'b0;
      rem_ff <= 33'h0;
      quo_ff <= 33'h0;
      cnt_ff <= 6'h00;
      byp_ff <= 1'b0;
      nonfinite_o <= 1'b0;
      norm_x_o <= 32'h0;
      norm_y_o <= 32'h0;
      norm_z_o <= 32'h0;
      recip_w_o <= 32'h0;
      scr_x_o <= 32'h0;
      scr_y_o <= 32'h0;
    end
    else
    begin
      case (st_ff)
        P_IDLE:
          if (go_i)
          begin
            // R07 bypass chooses divide
            byp_ff <= bypass_i;
            neg_ff <= pos_w_i[31];
            den_ff <= pos_w_i[31] ? 32'(-pos_w_i) : pos_w_i;
            rem_ff <= 33'h0;
            cnt_ff <= 6'h00;
            // R12 zero w flagged, saturated
            nonfinite_o <= !bypass_i && (pos_w_i == 32'h0);
            quo_ff <= {33{1'b1}};
            st_ff <= (bypass_i || pos_w_i == 32'h0) ? P_MAP : P_DIV;
          end
        P_DIV:
        begin
          // R11 reciprocal of clip w
          rem_ff <= ge ? 33'(shl - {2'b00, den_ff}) : shl[32:0];
          quo_ff <= {quo_ff[31:0], ge};
          cnt_ff <= cnt_ff + 6'h01;
          if (cnt_ff == fetch_pkg::DIV_LAST)
            st_ff <= P_MAP;
        end
        P_MAP:
        begin
          // R10 multiply by reciprocal
          norm_x_o <= nx;
          norm_y_o <= ny;
          norm_z_o <= nz;
          // R09 bypass passes w through
          recip_w_o <= byp_ff ? pos_w_i : recip;
          // R14 pixels, upper-left origin
          scr_x_o <= sx;
          scr_y_o <= sy;
          st_ff <= P_IDLE;
        end
        default:
          st_ff <= P_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: hw/vertex_fetch_stage.sv */
// vertex fetch front end: register port, fetch engine, packet stream
// assumes one memory answer per request, at least one clock after it
//
// Function
// R01 - first flag only on topology opening vertex
// R02 - last flag only on topology closing vertex
// R03 - topology and delimiters forwarded unchanged
// R04 - emitting unit generates its own delimiters
// R05 - shader threads attach delimiters on emit
// R06 - only clipper and setup use positions
// R07 - clipper consults divide bypass bit
// R08 - divide, clip-test, then viewport map (no clip-test here: divide, then map)
// R09 - bypass set: position passes undivided
// R10 - normalized xyz is xyz times 1/w
// R11 - reciprocal w equals one over w
// R12 - tolerate infinite or invalid divide results
// R13 - clip positions placed in vertex header (not done here: packets carry only the fetched data word)
// R14 - screen xy absolute pixels, upper-left origin
// R15 - index entries 8, 16 or 32 bits
// R16 - indices address per-vertex buffer data
// R17 - linear mode reads consecutive vertices
// R18 - cut index except rectangle and fan
// R19 - buffer is array of stride-sized structures
// R20 - select vertex or instance ordinal
// R21 - out-of-range fetch returns zero
// R22 - end is base plus byte length
// R23 - instance elements use same end
// R24 - whole element must be in range
`default_nettype none
module vertex_fetch_stage #(
  parameter int unsigned HANDLE_W = 8
) (
  input  wire logic                core_clk_i,
  input  wire logic                nrst_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [31:0]         reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic [31:0]              reg_rdata_o,
  output logic                     mem_req_o,
  output logic [31:0]              mem_addr_o,
  input  wire logic                mem_rvalid_i,
  input  wire logic [31:0]         mem_rdata_i,
  output logic                     pkt_valid_o,
  input  wire logic                pkt_ready_i,
  output logic [HANDLE_W-1:0]      pkt_handle_o,
  output logic [5:0]               pkt_topo_o,
  output logic                     pkt_first_o,
  output logic                     pkt_last_o,
  output logic [31:0]              pkt_data_o
);
  typedef enum logic [3:0] {
    S_IDLE, S_IDX_ADR, S_IDX_REQ, S_IDX_WAIT, S_VTX_CHK,
    S_VTX_REQ, S_VTX_WAIT, S_TAKE, S_EMIT, S_ADV
  } fstate_t;

  // software registers
  logic [31:0]         ctrl_ff;
  logic [31:0]         vcount_ff;
  logic [31:0]         first_ord_ff;
  logic [31:0]         idx_base_ff;
  logic [31:0]         src_base_ff;
  logic [31:0]         src_len_ff;
  logic [31:0]         stride_ff;
  logic [31:0]         inst_ord_ff;
  logic [31:0]         pos_x_ff;
  logic [31:0]         pos_y_ff;
  logic [31:0]         pos_z_ff;
  logic [31:0]         pos_w_ff;
  logic [31:0]         view_ff;
  logic [31:0]         pkt_cnt_ff;
  logic [31:0]         oob_cnt_ff;
  logic [31:0]         rdata_ff;

  // fetch engine state
  fstate_t             state_ff;
  logic [31:0]         i_ff;
  logic [31:0]         ord_ff;
  logic [31:0]         addr_ff;
  logic [1:0]          lane_ff;
  logic [5:0]          topo_ff;
  logic                first_ff;
  logic                done_ff;
  logic                new_v_ff;
  logic                emit_last_ff;
  logic [31:0]         take_ff;
  logic                pend_v_ff;
  logic [31:0]         pend_data_ff;
  logic                pend_first_ff;
  logic [HANDLE_W-1:0] pend_handle_ff;
  logic [HANDLE_W-1:0] handle_ff;

  // mapper results
  logic                pos_busy;
  logic                pos_nonfinite;
  logic [31:0]         norm_x;
  logic [31:0]         norm_y;
  logic [31:0]         norm_z;
  logic [31:0]         recip_w;
  logic [31:0]         scr_x;
  logic [31:0]         scr_y;

  // register port decode
  wire        wr_ctrl  = reg_wr_i && (reg_addr_i == fetch_pkg::A_CTRL);
  wire        busy     = (state_ff != S_IDLE);
  wire        start    = wr_ctrl && reg_wdata_i[fetch_pkg::C_START] && !busy;
  wire        pos_go   = reg_wr_i && (reg_addr_i == fetch_pkg::A_POSGO) && !pos_busy;
  wire        indexed  = ctrl_ff[fetch_pkg::C_INDEXED];
  wire [1:0]  isz      = ctrl_ff[fetch_pkg::C_ISZ +: 2];
  wire        inst_sel = ctrl_ff[fetch_pkg::C_INST];
  wire [31:0] status   = {29'h0, pos_nonfinite, pos_busy, busy};

  // index table lookup
  // R15 entry size 8, 16 or 32
  wire [31:0] idx_byte = idx_base_ff + (i_ff << isz);
  wire [31:0] idx_sh   = mem_rdata_i >> {lane_ff, 3'b000};
  wire [31:0] idx_val  = (isz == fetch_pkg::ISZ_8)  ? {24'h0, idx_sh[7:0]}  :
                         (isz == fetch_pkg::ISZ_16) ? {16'h0, idx_sh[15:0]} :
                         mem_rdata_i;
  wire [31:0] cut_val  = (isz == fetch_pkg::ISZ_8)  ? 32'h000000FF :
                         (isz == fetch_pkg::ISZ_16) ? 32'h0000FFFF :
                         32'hFFFFFFFF;
  // R18 cut recognised per topology
  wire        cut_ok   = fetch_pkg::CUT_MASK[topo_ff];
  wire        cut_hit  = cut_ok && (idx_val == cut_val);

  // element address and bounds
  // R20 vertex or instance ordinal
  wire [31:0] sel_ord  = inst_sel ? inst_ord_ff : ord_ff;
  // R19 ordinal times element stride
  wire [63:0] prod     = 64'(sel_ord) * 64'(stride_ff);
  wire [63:0] elem64   = {32'h0, src_base_ff} + prod;
  // R22 end is base plus length
  // R23 same end for instance data
  wire [63:0] end64    = {32'h0, src_base_ff} + {32'h0, src_len_ff};
  // R24 every element byte checked
  wire        in_range = (elem64 + fetch_pkg::ELEM_BYTES) <= end64;
  wire        last_i   = (i_ff + 32'h1) == vcount_ff;

  // read mux
  wire [31:0] rd_mux =
    (reg_addr_i == fetch_pkg::A_CTRL)   ? ctrl_ff       :
    (reg_addr_i == fetch_pkg::A_VCOUNT) ? vcount_ff     :
    (reg_addr_i == fetch_pkg::A_FIRST)  ? first_ord_ff  :
    (reg_addr_i == fetch_pkg::A_IDXB)   ? idx_base_ff   :
    (reg_addr_i == fetch_pkg::A_SRCB)   ? src_base_ff   :
    (reg_addr_i == fetch_pkg::A_SRCLEN) ? src_len_ff    :
    (reg_addr_i == fetch_pkg::A_STRIDE) ? stride_ff     :
    (reg_addr_i == fetch_pkg::A_INST)   ? inst_ord_ff   :
    (reg_addr_i == fetch_pkg::A_STATUS) ? status        :
    (reg_addr_i == fetch_pkg::A_PKTCNT) ? pkt_cnt_ff    :
    (reg_addr_i == fetch_pkg::A_OOBCNT) ? oob_cnt_ff    :
    (reg_addr_i == fetch_pkg::A_POSX)   ? pos_x_ff      :
    (reg_addr_i == fetch_pkg::A_POSY)   ? pos_y_ff      :
    (reg_addr_i == fetch_pkg::A_POSZ)   ? pos_z_ff      :
    (reg_addr_i == fetch_pkg::A_POSW)   ? pos_w_ff      :
    (reg_addr_i == fetch_pkg::A_VIEW)   ? view_ff       :
    (reg_addr_i == fetch_pkg::A_NORMX)  ? norm_x        :
    (reg_addr_i == fetch_pkg::A_NORMY)  ? norm_y        :
    (reg_addr_i == fetch_pkg::A_NORMZ)  ? norm_z        :
    (reg_addr_i == fetch_pkg::A_RECIPW) ? recip_w       :
    (reg_addr_i == fetch_pkg::A_SCRX)   ? scr_x         :
    (reg_addr_i == fetch_pkg::A_SCRY)   ? scr_y         :
    32'h0;

  // outputs
  assign reg_rdata_o  = rdata_ff;
  assign mem_req_o    = (state_ff == S_IDX_REQ) || (state_ff == S_VTX_REQ);
  assign mem_addr_o   = addr_ff;
  assign pkt_valid_o  = (state_ff == S_EMIT);
  assign pkt_data_o   = pend_data_ff;
  assign pkt_handle_o = pend_handle_ff;
  // R03 topology forwarded unchanged
  assign pkt_topo_o   = topo_ff;
  assign pkt_first_o  = pend_first_ff;
  assign pkt_last_o   = emit_last_ff;

  // register writes
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_ff <= fetch_pkg::RST_REG;
      vcount_ff <= fetch_pkg::RST_REG;
      first_ord_ff <= fetch_pkg::RST_REG;
      idx_base_ff <= fetch_pkg::RST_REG;
      src_base_ff <= fetch_pkg::RST_REG;
      src_len_ff <= fetch_pkg::RST_REG;
      stride_ff <= fetch_pkg::RST_REG;
      inst_ord_ff <= fetch_pkg::RST_REG;
      pos_x_ff <= fetch_pkg::RST_REG;
      pos_y_ff <= fetch_pkg::RST_REG;
      pos_z_ff <= fetch_pkg::RST_REG;
      pos_w_ff <= fetch_pkg::RST_REG;
      view_ff <= fetch_pkg::RST_REG;
    end
    else if (reg_wr_i && !busy && !pos_busy)
    begin
      case (reg_addr_i)
        fetch_pkg::A_CTRL:   ctrl_ff <= reg_wdata_i & fetch_pkg::CTRL_WMASK;
        fetch_pkg::A_VCOUNT: vcount_ff <= reg_wdata_i;
        fetch_pkg::A_FIRST:  first_ord_ff <= reg_wdata_i;
        fetch_pkg::A_IDXB:   idx_base_ff <= reg_wdata_i;
        fetch_pkg::A_SRCB:   src_base_ff <= reg_wdata_i;
        fetch_pkg::A_SRCLEN: src_len_ff <= reg_wdata_i;
        fetch_pkg::A_STRIDE: stride_ff <= reg_wdata_i;
        fetch_pkg::A_INST:   inst_ord_ff <= reg_wdata_i;
        fetch_pkg::A_POSX:   pos_x_ff <= reg_wdata_i;
        fetch_pkg::A_POSY:   pos_y_ff <= reg_wdata_i;
        fetch_pkg::A_POSZ:   pos_z_ff <= reg_wdata_i;
        fetch_pkg::A_POSW:   pos_w_ff <= reg_wdata_i;
        fetch_pkg::A_VIEW:   view_ff <= reg_wdata_i;
        default:             ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // read data, one cycle after strobe
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_ff <= 32'h0;
    else
      rdata_ff <= reg_rd_i ? rd_mux : 32'h0;
  end

  // fetch engine
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_ff <= S_IDLE;
      i_ff <= 32'h0;
      ord_ff <= 32'h0;
      addr_ff <= 32'h0;
      lane_ff <= 2'h0;
      topo_ff <= 6'h00;
      first_ff <= 1'b0;
      done_ff <= 1'b0;
      new_v_ff <= 1'b0;
      emit_last_ff <= 1'b0;
      take_ff <= 32'h0;
      pend_v_ff <= 1'b0;
      pend_data_ff <= 32'h0;
      pend_first_ff <= 1'b0;
      pend_handle_ff <= '0;
      handle_ff <= '0;
      pkt_cnt_ff <= 32'h0;
      oob_cnt_ff <= 32'h0;
    end
    else
    begin
      case (state_ff)
        S_IDLE:
          if (start && reg_wdata_i != 32'h0 && vcount_ff != 32'h0)
          begin
            i_ff <= 32'h0;
            // R17 linear starts at first ordinal
            ord_ff <= first_ord_ff;
            topo_ff <= reg_wdata_i[fetch_pkg::C_TOPO +: fetch_pkg::TOPO_W];
            first_ff <= 1'b1;
            done_ff <= 1'b0;
            pend_v_ff <= 1'b0;
            new_v_ff <= 1'b0;
            state_ff <= reg_wdata_i[fetch_pkg::C_INDEXED] ? S_IDX_ADR : S_VTX_CHK;
          end
        S_IDX_ADR:
        begin
          addr_ff <= {idx_byte[31:2], 2'b00};
          lane_ff <= idx_byte[1:0];
          state_ff <= S_IDX_REQ;
        end
        S_IDX_REQ:
          state_ff <= S_IDX_WAIT;
        S_IDX_WAIT:
          if (mem_rvalid_i)
          begin
            if (cut_hit)
            begin
              // R01 next vertex opens topology
              first_ff <= 1'b1;
              emit_last_ff <= 1'b1;
              state_ff <= pend_v_ff ? S_EMIT : S_ADV;
            end
            else
            begin
              // R16 index gives vertex ordinal
              ord_ff <= idx_val;
              state_ff <= S_VTX_CHK;
            end
          end
        S_VTX_CHK:
          if (in_range)
          begin
            addr_ff <= elem64[31:0];
            state_ff <= S_VTX_REQ;
          end
          else
          begin
            // R21 out of range reads zero
            take_ff <= 32'h0;
            oob_cnt_ff <= oob_cnt_ff + 32'h1;
            state_ff <= S_TAKE;
          end
        S_VTX_REQ:
          state_ff <= S_VTX_WAIT;
        S_VTX_WAIT:
          if (mem_rvalid_i)
          begin
            take_ff <= mem_rdata_i;
            state_ff <= S_TAKE;
          end
        S_TAKE:
          if (!pend_v_ff)
          begin
            // R04 delimiters made here
            pend_v_ff <= 1'b1;
            pend_data_ff <= take_ff;
            pend_first_ff <= first_ff;
            pend_handle_ff <= handle_ff;
            handle_ff <= handle_ff + 1'b1;
            first_ff <= 1'b0;
            state_ff <= S_ADV;
          end
          else
          begin
            // R02 a vertex follows, not last
            emit_last_ff <= 1'b0;
            new_v_ff <= 1'b1;
            state_ff <= S_EMIT;
          end
        S_EMIT:
          if (pkt_ready_i)
          begin
            pkt_cnt_ff <= pkt_cnt_ff + 32'h1;
            if (new_v_ff)
            begin
              pend_data_ff <= take_ff;
              pend_first_ff <= first_ff;
              pend_handle_ff <= handle_ff;
              handle_ff <= handle_ff + 1'b1;
              first_ff <= 1'b0;
              new_v_ff <= 1'b0;
            end
            else
              pend_v_ff <= 1'b0;
            state_ff <= done_ff ? S_IDLE : S_ADV;
          end
        S_ADV:
          if (last_i)
          begin
            // R02 closing vertex marked last
            emit_last_ff <= 1'b1;
            done_ff <= 1'b1;
            state_ff <= pend_v_ff ? S_EMIT : S_IDLE;
          end
          else
          begin
            i_ff <= i_ff + 32'h1;
            ord_ff <= ord_ff + 32'h1;
            state_ff <= indexed ? S_IDX_ADR : S_VTX_CHK;
          end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

  // position mapping for clipper and setup
  // R06 positions reach only this mapper and the register read mux
  // R08 divide, then viewport map
  clip_pos_map u_map (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .go_i        (pos_go),
    .bypass_i    (ctrl_ff[fetch_pkg::C_BYPASS]),
    .pos_x_i     (pos_x_ff),
    .pos_y_i     (pos_y_ff),
    .pos_z_i     (pos_z_ff),
    .pos_w_i     (pos_w_ff),
    .view_w_i    (view_ff[15:0]),
    .view_h_i    (view_ff[31:16]),
    .busy_o      (pos_busy),
    .nonfinite_o (pos_nonfinite),
    .norm_x_o    (norm_x),
    .norm_y_o    (norm_y),
    .norm_z_o    (norm_z),
    .recip_w_o   (recip_w),
    .scr_x_o     (scr_x),
    .scr_y_o     (scr_y)
  );
endmodule
`default_nettype wire

/* File: sim/mem_model.sv */
// memory model: answers each word read after a prompt or slow delay
// assumes one read outstanding, request seen on a rising edge
`default_nettype none
module mem_model (
  input  wire logic        clk_i,
  input  wire logic        slow_i,
  input  wire logic        mem_req_i,
  input  wire logic [31:0] mem_addr_i,
  output var logic         rvalid_o,
  output var logic  [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] a;
  // low region holds small indices, the rest a tagged address
  function automatic logic [31:0] word(input logic [31:0] x);
    return x < 32'h1000 ? {28'h0, x[5:2] ^ 4'h3} : x ^ 32'h5A5A0000;
  endfunction
  initial
  begin
    rvalid_o = 1'b0;
    rdata_o = 32'h0;
    forever
    begin
      @(posedge clk_i);
      if (mem_req_i)
      begin
        a = mem_addr_i;
        repeat (slow_i ? 5 : 0) @(posedge clk_i);
        rvalid_o <= 1'b1;
        rdata_o <= word(a);
        @(posedge clk_i);
        rvalid_o <= 1'b0;
        rdata_o <= ~word(a);
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/vertex_fetch_chk.sv */
// checker: port assertions for the vertex fetch front end
// assumes it is bound onto vertex_fetch_stage
`default_nettype none
module vertex_fetch_chk #(
  parameter int unsigned HANDLE_W = 8
) (
  input wire logic                core_clk_i,
  input wire logic                nrst_i,
  input wire logic [7:0]          reg_addr_i,
  input wire logic                reg_rd_i,
  input wire logic [31:0]         reg_rdata_o,
  input wire logic                mem_req_o,
  input wire logic [31:0]         mem_addr_o,
  input wire logic                mem_rvalid_i,
  input wire logic                pkt_valid_o,
  input wire logic                pkt_ready_i,
  input wire logic [HANDLE_W-1:0] pkt_handle_o,
  input wire logic [5:0]          pkt_topo_o,
  input wire logic                pkt_first_o,
  input wire logic                pkt_last_o,
  input wire logic [31:0]         pkt_data_o
);
  logic wait_ff;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  always_ff @(posedge core_clk_i or negedge nrst_i)
    if (!nrst_i) wait_ff <= 1'b0;
    else if (mem_req_o) wait_ff <= 1'b1;
    else if (mem_rvalid_i) wait_ff <= 1'b0;
  chk_pkt_hold:
    assert property (pkt_valid_o && !pkt_ready_i |=> pkt_valid_o
      && $stable({pkt_handle_o, pkt_topo_o, pkt_first_o, pkt_last_o, pkt_data_o}))
    else $error("packet changed while stalled");
  chk_pkt_gap:
    assert property (pkt_valid_o && pkt_ready_i |=> !pkt_valid_o)
    else $error("packet valid without gap");
  chk_one_wait:
    assert property (!(mem_req_o && wait_ff))
    else $error("second read while one outstanding");
  chk_word_align:
    assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0)
    else $error("read address not word aligned");
  chk_answer_gap:
    assert property (mem_rvalid_i && wait_ff |=> !mem_req_o)
    else $error("read right after answer");
  chk_rd_idle:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  chk_start_bit:
    assert property (reg_rd_i && reg_addr_i == fetch_pkg::A_CTRL |=> !reg_rdata_o[0])
    else $error("start bit reads back set");
  chk_unmapped_rd:
    assert property (reg_rd_i && reg_addr_i > fetch_pkg::A_SCRY |=> reg_rdata_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind vertex_fetch_stage vertex_fetch_chk #(.HANDLE_W(HANDLE_W)) u_chk (.core_clk_i,
  .nrst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .mem_req_o, .mem_addr_o, .mem_rvalid_i,
  .pkt_valid_o, .pkt_ready_i, .pkt_handle_o, .pkt_topo_o, .pkt_first_o, .pkt_last_o,
  .pkt_data_o);
`default_nettype wire

/* File: sim/test_vertex_fetch_stage.sv */
// testbench: register, draw and mapper scenarios for vertex_fetch_stage
// assumes mem_model answers the memory port
`default_nettype none
module test_vertex_fetch_stage;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i, nrst_i, reg_wr_i, reg_rd_i, mem_rvalid_i, pkt_ready_i, slow;
  logic mem_req_o, pkt_valid_o, pkt_first_o, pkt_last_o;
  logic [7:0] reg_addr_i, pkt_handle_o;
  logic [5:0] pkt_topo_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, mem_addr_o, mem_rdata_i, pkt_data_o;
  logic [31:0] seed = 32'h29F644B6;
  logic [31:0] pq[$];
  logic [15:0] fq[$];
  int num_errors, tests_run;
  vertex_fetch_stage dut (.core_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .mem_req_o, .mem_addr_o, .mem_rvalid_i, .mem_rdata_i,
    .pkt_valid_o, .pkt_ready_i, .pkt_handle_o, .pkt_topo_o, .pkt_first_o, .pkt_last_o,
    .pkt_data_o);
  mem_model u_mem (.clk_i(core_clk_i), .slow_i(slow), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    @(posedge core_clk_i);
    d = reg_rdata_o;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task automatic idle(input logic [31:0] b);
    logic [31:0] s;
    s = b;
    for (int k = 0; k < 300 && (s & b) != 0; k++) rd(fetch_pkg::A_STATUS, s);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
  begin
    pkt_ready_i <= rnd() % 3 != 0;
    slow <= rnd() % 2 != 0;
    if (nrst_i && pkt_valid_o && pkt_ready_i)
    begin
      pq.push_back(pkt_data_o);
      fq.push_back({pkt_handle_o, pkt_first_o, pkt_last_o, pkt_topo_o});
    end
  end
  initial
  begin
    #3000000;
    num_errors++;
    summarize();
  end
  initial
  begin
    logic [31:0] st, o, e, r;
    logic [5:0] tp;
    {nrst_i, reg_wr_i, reg_rd_i, pkt_ready_i, slow} = 5'h0;
    reg_addr_i = 8'h0;
    reg_wdata_i = 32'h0;
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    for (int a = 4; a <= 40; a += 4) rc(8'(a), fetch_pkg::RST_REG);
    rc(8'hFC, 32'h0);
    // linear, instance and indexed draws, tail element out
    for (int m = 0; m < 3; m++)
    begin
      st = 32'h4 * (rnd() % 4 + 1);
      tp = m == 0 ? 6'h05 : m == 1 ? fetch_pkg::T_RECTLIST : fetch_pkg::T_FAN_NOSTP;
      wr(fetch_pkg::A_SRCB, 32'h2000);
      wr(fetch_pkg::A_SRCLEN, 3 * st + 2);
      wr(fetch_pkg::A_STRIDE, st);
      wr(fetch_pkg::A_VCOUNT, 32'h4);
      wr(fetch_pkg::A_FIRST, 32'h0);
      wr(fetch_pkg::A_INST, 32'h2);
      wr(fetch_pkg::A_IDXB, 32'h100);
      pq.delete();
      fq.delete();
      wr(fetch_pkg::A_CTRL, {18'h0, tp, 2'h0, m == 1, 1'b0, 2'h2, m == 2, 1'b1});
      for (int k = 0; k < 3000 && pq.size() < 4; k++) @(posedge core_clk_i);
      idle(32'h1);
      chk("count", pq.size(), 32'h4);
      for (int k = 0; k < 4 && k < pq.size(); k++)
      begin
        o = m == 1 ? 2 : m == 2 ? u_mem.word(32'h100 + 4 * k) : k;
        e = o * st + 4 <= 3 * st + 2 ? u_mem.word(32'h2000 + o * st) : 32'h0;
        chk("data", pq[k], e);
        chk("flags", {16'h0, fq[k]}, {16'h0, 8'(4 * m + k), k == 0, k == 3, tp});
      end
      rc(fetch_pkg::A_PKTCNT, 4 * (m + 1));
    end
    // divide, bypass, then zero w
    for (int c = 0; c < 3; c++)
    begin
      r = rnd();
      wr(fetch_pkg::A_CTRL, c == 1 ? 32'h10 : 32'h0);
      wr(fetch_pkg::A_POSX, c == 1 ? r : 32'h20000);
      wr(fetch_pkg::A_POSY, 32'h0);
      wr(fetch_pkg::A_POSZ, 32'h10000);
      wr(fetch_pkg::A_POSW, c == 2 ? 32'h0 : 32'h20000);
      wr(fetch_pkg::A_VIEW, 32'h320064);
      wr(fetch_pkg::A_POSGO, 32'h1);
      idle(32'h2);
      if (c == 0) rc(fetch_pkg::A_NORMX, 32'h10000);
      if (c == 0) rc(fetch_pkg::A_NORMZ, 32'h8000);
      if (c == 0) rc(fetch_pkg::A_RECIPW, 32'h8000);
      if (c == 0) rc(fetch_pkg::A_SCRX, 32'h64);
      if (c == 0) rc(fetch_pkg::A_SCRY, 32'h19);
      if (c == 1) rc(fetch_pkg::A_NORMX, r);
      if (c == 1) rc(fetch_pkg::A_SCRX, $signed(r) >>> 16);
      if (c == 2) rc(fetch_pkg::A_STATUS, 32'h4);
      if (c == 2) rc(fetch_pkg::A_RECIPW, fetch_pkg::SAT_POS);
    end
    summarize();
  end
endmodule
`default_nettype wire
